// ---- common/dcfpf_pkg.sv ----
package dcfpf_pkg;

   // ----------------------------------------
   // Sizes
   // ----------------------------------------
   localparam int DATA_W = 36;
   localparam int MEM_DEPTH = 1024;
   localparam int STAGE_DEPTH = 4;
   localparam int OFS_PRESET = 8;

   // ----------------------------------------
   // Control states
   // ----------------------------------------
   typedef enum logic [2:0] {
      DCFPF_ST_CFG = 3'h1,
      DCFPF_ST_SER = 3'h2,
      DCFPF_ST_RUN = 3'h4
   } dcfpf_state_e;

endpackage

// ---- common/dcfpf_stream_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface dcfpf_stream_if #(parameter int W = 36);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface // dcfpf_stream_if
`default_nettype wire

// ---- hw/dcfpf_sync.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcfpf_sync #(
   parameter int W = 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic [W-1:0] i_d,
   output logic [W-1:0] o_q
);
   logic [W-1:0] meta_r;

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         meta_r <= '0;
         o_q <= '0;
      end else begin
         meta_r <= i_d;
         o_q <= meta_r;
      end
   end
endmodule // dcfpf_sync
`default_nettype wire

// ---- hw/dcfpf_fifo.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcfpf_fifo #(
   parameter int W = 36,
   parameter int DEPTH = 4,
   parameter int LW = $clog2(DEPTH) + 1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   dcfpf_stream_if.snk s_wr,
   dcfpf_stream_if.src s_rd,
   output logic [LW-1:0] o_level
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem_r [DEPTH];
   logic [LW-1:0] wp_r;
   logic [LW-1:0] rp_r;
   logic push;
   logic pop;

   assign o_level = wp_r - rp_r;
   assign s_wr.ready = (o_level != LW'(DEPTH));
   assign s_rd.valid = (o_level != '0);
   assign s_rd.data = mem_r[rp_r[AW-1:0]];
   assign push = s_wr.valid & s_wr.ready;
   assign pop = s_rd.valid & s_rd.ready;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem_r[wp_r[AW-1:0]] <= s_wr.data;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_r + LW'(push);
         rp_r <= rp_r + LW'(pop);
      end
   end
endmodule // dcfpf_fifo
`default_nettype wire

// ---- hw/dcfpf_top.sv ----
`timescale 1ns/1ns
`default_nettype none
//Contract
// R01 - Port B data floats while chip select is high or direction is low.
// R02 - Port B data driven only with chip select low and direction high.
// R03 - Port A data floats if chip select or direction high, driven when both low.
// R04 - FIFO write on port A edge: selected, direction high, enable, no mailbox, space flag.
// R05 - FIFO read on port B edge: selected, direction high, enable, no mailbox, read flag.
// R06 - Port B decode: mailbox write, mailbox read clearing mail flag, else nothing.
// R07 - Port B direction is inverted: high reads, low writes.
// R08 - Serial offset load keeps space flag low; it rises edge after last bit.
// R09 - Serial offsets must lie within the range allowed for the depth.
// R10 - Fall-through, output flag low: next word loads as the flag rises.
// R11 - Fall-through, output flag high: word loads only on a selected read.
// R12 - Standard mode: word loads into output register only on a selected read.
// R13 - Flags pass two stages on their own port clock.
// R14 - Fall-through flag high means new word; low keeps old word, ignores reads.
// R15 - Standard flag high means data in memory; low ignores reads.
// R16 - Read pointer advances whenever a word enters the output register.
// R17 - Fall-through: flag rises and word loads on third port B edge.
// R18 - Standard: no-data flag rises on second port B edge after write.
// R19 - A port B edge too close after a write does not count.
// R20 - Flag levels follow memory fill against empty, offsets and full depth.
// R21 - Output register word is not counted in memory fill.
// R22 - A location shifted out to the output register is free again.
// R23 - Space flag low means full; writes are ignored.
// R24 - Timing mode sampled after reset and held fixed.
// R25 - Pointers wrap; fill equals write minus read modulo twice depth.
module dcfpf_top #(
   parameter int DEPTH = dcfpf_pkg::MEM_DEPTH,
   parameter int W = dcfpf_pkg::DATA_W,
   parameter int OFS_PRESET = dcfpf_pkg::OFS_PRESET
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_port_a_clock,
   input wire logic i_port_a_chip_select_n,
   input wire logic i_port_a_direction,
   input wire logic i_port_a_enable,
   input wire logic i_port_a_mailbox_select,
   input wire logic [W-1:0] i_port_a_data,
   output logic [W-1:0] o_port_a_data,
   output logic o_port_a_data_oe,
   input wire logic i_port_b_clock,
   input wire logic i_port_b_chip_select_n,
   input wire logic i_port_b_direction,
   input wire logic i_port_b_enable,
   input wire logic i_port_b_mailbox_select,
   input wire logic [W-1:0] i_port_b_data,
   output logic [W-1:0] o_port_b_data,
   output logic o_port_b_data_oe,
   input wire logic i_endian_timing_select,
   input wire logic i_serial_program_n,
   input wire logic i_serial_enable_n,
   input wire logic i_serial_data,
   output logic o_read_side_flag,
   output logic o_write_side_flag,
   output logic o_almost_empty_flag_n,
   output logic o_almost_full_flag_n,
   output logic o_mail_a_to_b_flag_n,
   output logic o_mail_b_to_a_flag_n,
   output logic o_fall_through_mode
);
   localparam int AW = $clog2(DEPTH);
   localparam int PW = AW + 1;
   localparam int OW = AW;
   localparam int SBITS = 2 * OW;
   localparam int BCW = $clog2(SBITS);
   localparam int SDEP = dcfpf_pkg::STAGE_DEPTH;
   localparam int LW = $clog2(SDEP) + 1;
   localparam int SYW = 2 * (W + 5) + 4;

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   logic [SYW-1:0] pin_raw, pin_s;
   logic a_clk_s, a_csel, a_dir, a_en, a_mbx;
   logic b_clk_s, b_csel, b_dir, b_en, b_mbx;
   logic [W-1:0] a_din, b_din;
   logic ets_s, sprog_n_s, sen_n_s, sd_s;
   // Chip selects are carried active high so reset means deselected
   assign pin_raw = {i_port_a_clock, ~i_port_a_chip_select_n,
      i_port_a_direction, i_port_a_enable, i_port_a_mailbox_select,
      i_port_a_data, i_port_b_clock, ~i_port_b_chip_select_n,
      i_port_b_direction, i_port_b_enable, i_port_b_mailbox_select,
      i_port_b_data, i_endian_timing_select, i_serial_program_n,
      i_serial_enable_n, i_serial_data};
   dcfpf_sync #(.W(SYW)) u_sync (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_d(pin_raw),
      .o_q(pin_s)
   );
   assign {a_clk_s, a_csel, a_dir, a_en, a_mbx, a_din,
      b_clk_s, b_csel, b_dir, b_en, b_mbx, b_din,
      ets_s, sprog_n_s, sen_n_s, sd_s} = pin_s;

   // ----------------------------------------
   // State
   // ----------------------------------------
   dcfpf_pkg::dcfpf_state_e state_r, state_nxt;
   logic a_clk_d_r, b_clk_d_r, ft_mode_r;
   logic [PW-1:0] wptr_r, rptr_r, rptr_nxt;
   logic [PW-1:0] rp_a1_r, wp_b1_r, wp_b2_r;
   logic [W-1:0] mem_r [DEPTH];
   logic [W-1:0] outreg_r, mailbox_a_to_b_r, mailbox_b_to_a_r;
   logic [W-1:0] a_dout_r, b_dout_r;
   logic a_oe_r, b_oe_r;
   logic wflag_r, rflag_r, ae_n_r, af_n_r, mail_a_to_b_flag_n_r, mail_b_to_a_flag_n_r;
   logic [OW-1:0] ofs_x_r, ofs_y_r;
   logic [SBITS-1:0] shreg_r, shreg_nxt;
   logic [BCW-1:0] bitcnt_r;
   logic [LW-1:0] stg_level;
   // ----------------------------------------
   // Port decode
   // ----------------------------------------
   logic a_rise, b_rise, a_sel, b_sel;
   logic a_fifo_wr, a_mail_wr, a_mail_rd;
   logic b_fifo_rd, b_mail_wr, b_mail_rd;
   logic ser_bit, ser_last, running, mem_free, mem_wr, ft_load, std_load, load;
   logic [PW-1:0] cnt_true, cnt_a, cnt_b2;
   logic wflag_nxt, rflag_nxt, ae_n_nxt, af_n_nxt;
   dcfpf_stream_if #(.W(W)) push_if ();
   dcfpf_stream_if #(.W(W)) pop_if ();
   assign a_rise = a_clk_s & ~a_clk_d_r;
   assign b_rise = b_clk_s & ~b_clk_d_r;
   assign running = (state_r == dcfpf_pkg::DCFPF_ST_RUN);
   assign a_sel = a_rise & a_csel & a_en;
   assign b_sel = b_rise & b_csel & b_en;
   assign a_fifo_wr = a_sel & a_dir & ~a_mbx & wflag_r & running & push_if.ready; // R04 R23
   assign a_mail_wr = a_sel & a_dir & a_mbx & mail_a_to_b_flag_n_r;
   assign a_mail_rd = a_sel & ~a_dir & a_mbx;
   assign b_fifo_rd = b_sel & b_dir & ~b_mbx & rflag_r; // R05 R07 R14 R15
   assign b_mail_rd = b_sel & b_dir & b_mbx; // R06
   assign b_mail_wr = b_sel & ~b_dir & b_mbx & mail_b_to_a_flag_n_r; // R06
   assign ser_bit = a_rise & ~sen_n_s & (state_r == dcfpf_pkg::DCFPF_ST_SER);
   assign ser_last = ser_bit & (bitcnt_r == BCW'(SBITS - 1));
   assign shreg_nxt = {shreg_r[SBITS-2:0], sd_s};

   // ----------------------------------------
   // Staging buffer and memory
   // ----------------------------------------
   assign push_if.data = a_din;
   assign push_if.valid = a_fifo_wr;
   assign cnt_true = wptr_r - rptr_r; // R25
   assign mem_free = ~cnt_true[AW]; // R22
   assign pop_if.ready = mem_free;
   assign mem_wr = pop_if.valid & mem_free;
   dcfpf_fifo #(.W(W), .DEPTH(SDEP), .LW(LW)) u_stage (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .s_wr(push_if),
      .s_rd(pop_if),
      .o_level(stg_level)
   );
   always_ff @(posedge i_clk) begin
      if (mem_wr) begin
         mem_r[wptr_r[AW-1:0]] <= pop_if.data;
      end
   end

   // ----------------------------------------
   // Read side, on port B edges
   // ----------------------------------------
   assign cnt_b2 = wp_b2_r - rptr_r;
   assign ft_load = b_rise & (cnt_b2 != '0) & (~rflag_r | b_fifo_rd); // R10 R11 R17
   assign std_load = b_fifo_rd; // R12
   assign load = ft_mode_r ? ft_load : std_load;
   assign rptr_nxt = rptr_r + PW'(load); // R16
   assign rflag_nxt = ft_mode_r ? (ft_load | (rflag_r & ~b_fifo_rd))
      : ((wp_b1_r - rptr_nxt) != '0); // R18
   assign ae_n_nxt = (wp_b1_r - rptr_nxt) > PW'(ofs_x_r); // R20 R21

   // ----------------------------------------
   // Write side, on port A edges
   // ----------------------------------------
   assign cnt_a = wptr_r - rp_a1_r + PW'(stg_level) + PW'(a_fifo_wr);
   assign wflag_nxt = running & (cnt_a < PW'(DEPTH)); // R08 R20
   assign af_n_nxt = cnt_a < (PW'(DEPTH) - PW'(ofs_y_r)); // R20

   // ----------------------------------------
   // Configuration sequence
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dcfpf_pkg::DCFPF_ST_CFG: begin
            if (a_rise) begin
               state_nxt = sprog_n_s ? dcfpf_pkg::DCFPF_ST_RUN : dcfpf_pkg::DCFPF_ST_SER;
            end
         end
         dcfpf_pkg::DCFPF_ST_SER: begin
            if (ser_last) begin
               state_nxt = dcfpf_pkg::DCFPF_ST_RUN;
            end
         end
         dcfpf_pkg::DCFPF_ST_RUN: state_nxt = dcfpf_pkg::DCFPF_ST_RUN;
         default: state_nxt = dcfpf_pkg::DCFPF_ST_CFG;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_r <= dcfpf_pkg::DCFPF_ST_CFG;
         ft_mode_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (a_rise && state_r == dcfpf_pkg::DCFPF_ST_CFG) begin
            ft_mode_r <= ~ets_s; // R24
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         shreg_r <= '0;
         bitcnt_r <= '0;
         ofs_x_r <= OW'(OFS_PRESET);
         ofs_y_r <= OW'(OFS_PRESET);
      end else if (ser_bit) begin
         shreg_r <= shreg_nxt;
         bitcnt_r <= bitcnt_r + BCW'(1);
         if (ser_last) begin
            ofs_y_r <= shreg_nxt[SBITS-1:OW];
            ofs_x_r <= shreg_nxt[OW-1:0];
         end
      end
   end

   // ----------------------------------------
   // Pointers and flag pipelines
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         a_clk_d_r <= 1'b0;
         b_clk_d_r <= 1'b0;
         wptr_r <= '0;
         rptr_r <= '0;
         rp_a1_r <= '0;
         wp_b1_r <= '0;
         wp_b2_r <= '0;
      end else begin
         a_clk_d_r <= a_clk_s;
         b_clk_d_r <= b_clk_s;
         wptr_r <= wptr_r + PW'(mem_wr);
         rptr_r <= rptr_nxt;
         if (a_rise) begin
            rp_a1_r <= rptr_r; // R13
         end
         if (b_rise) begin
            wp_b1_r <= wptr_r; // R13 R19
            wp_b2_r <= wp_b1_r;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         wflag_r <= 1'b0;
         af_n_r <= 1'b1;
         rflag_r <= 1'b0;
         ae_n_r <= 1'b0;
         outreg_r <= '0;
      end else begin
         if (a_rise) begin
            wflag_r <= wflag_nxt;
            af_n_r <= af_n_nxt;
         end
         if (b_rise) begin
            rflag_r <= rflag_nxt;
            ae_n_r <= ae_n_nxt;
         end
         if (load) begin
            outreg_r <= mem_r[rptr_r[AW-1:0]];
         end
      end
   end

   // ----------------------------------------
   // Mailboxes; a new write wins over a read
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         mail_a_to_b_flag_n_r <= 1'b1;
         mail_b_to_a_flag_n_r <= 1'b1;
         mailbox_a_to_b_r <= '0;
         mailbox_b_to_a_r <= '0;
      end else begin
         if (a_mail_wr) begin
            mailbox_a_to_b_r <= a_din;
            mail_a_to_b_flag_n_r <= 1'b0;
         end else if (b_mail_rd) begin
            mail_a_to_b_flag_n_r <= 1'b1; // R06
         end
         if (b_mail_wr) begin
            mailbox_b_to_a_r <= b_din;
            mail_b_to_a_flag_n_r <= 1'b0;
         end else if (a_mail_rd) begin
            mail_b_to_a_flag_n_r <= 1'b1;
         end
      end
   end

   // ----------------------------------------
   // Data buses
   // ----------------------------------------
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         a_oe_r <= 1'b0;
         b_oe_r <= 1'b0;
         a_dout_r <= '0;
         b_dout_r <= '0;
      end else begin
         a_oe_r <= a_csel & ~a_dir; // R03
         b_oe_r <= b_csel & b_dir; // R01 R02 R07
         a_dout_r <= mailbox_b_to_a_r;
         b_dout_r <= b_mbx ? mailbox_a_to_b_r : outreg_r;
      end
   end

   assign o_port_a_data = a_dout_r;
   assign o_port_a_data_oe = a_oe_r;
   assign o_port_b_data = b_dout_r;
   assign o_port_b_data_oe = b_oe_r;
   assign o_read_side_flag = rflag_r;
   assign o_write_side_flag = wflag_r;
   assign o_almost_empty_flag_n = ae_n_r;
   assign o_almost_full_flag_n = af_n_r;
   assign o_mail_a_to_b_flag_n = mail_a_to_b_flag_n_r;
   assign o_mail_b_to_a_flag_n = mail_b_to_a_flag_n_r;
   assign o_fall_through_mode = ft_mode_r;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   sequence s_ft_idle_data;
      ft_mode_r && b_rise && !rflag_r && (cnt_b2 != '0);
   endsequence
   sequence s_std_read;
      !ft_mode_r && b_fifo_rd;
   endsequence

   AST_B_FLOAT: assert property (!b_csel || !b_dir |=> !o_port_b_data_oe) // R01
      else $error("port B drives while deselected");
   AST_B_DRIVE: assert property (b_csel && b_dir |=> o_port_b_data_oe) // R02
      else $error("port B not driven on read select");
   AST_A_OE: assert property (a_csel && !a_dir |=> o_port_a_data_oe) // R03
      else $error("port A not driven on read select");
   AST_A_FLOAT: assert property (!a_csel || a_dir |=> !o_port_a_data_oe) // R03
      else $error("port A drives while deselected");
   AST_FT_LOAD: assert property (s_ft_idle_data |=> rflag_r && rptr_r == $past(rptr_r) + 1'b1) // R10
      else $error("fall-through word not loaded as flag rises");
   AST_STD_LOAD: assert property (s_std_read |=> rptr_r == $past(rptr_r) + 1'b1) // R16
      else $error("read pointer did not advance on read");
   AST_RD_IGNORED: assert property (b_rise && !o_read_side_flag && !ft_mode_r |=> $stable(rptr_r)) // R15
      else $error("read taken while no-data flag low");
   AST_WR_IGNORED: assert property (!o_write_side_flag |-> !push_if.valid) // R23
      else $error("write taken while space flag low");
   AST_SER_HOLD: assert property (state_r == dcfpf_pkg::DCFPF_ST_SER |=> !o_write_side_flag) // R08
      else $error("space flag high during serial load");
   AST_MAIL_CLR: assert property (b_mail_rd && !a_mail_wr |=> o_mail_a_to_b_flag_n) // R06
      else $error("mail flag not cleared by port B read");
   AST_FULL_STALL: assert property (cnt_true == PW'(DEPTH) |-> !mem_wr) // R20
      else $error("memory written while full");
endmodule // dcfpf_top
`default_nettype wire

// ---- tb/dcfpf_port_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module dcfpf_port_host #(
   parameter int HALF = 5,
   parameter int W = 36
) (
   input wire logic i_clk,
   input wire logic i_host_oe,
   input wire logic [W-1:0] i_host_data,
   input wire logic i_dev_oe,
   input wire logic [W-1:0] i_dev_data,
   output logic o_port_clock,
   output logic [W-1:0] o_bus
);
   // ----------------------------------------
   // Free-running port clock
   // ----------------------------------------
   int cnt = 0;
   logic [W-1:0] last = '0;
   initial o_port_clock = 1'b0;
   always @(posedge i_clk) begin
      cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
      if (cnt == HALF - 1) begin
         o_port_clock <= ~o_port_clock;
      end
      if (i_host_oe | i_dev_oe) begin
         last <= o_bus;
      end
   end
   // ----------------------------------------
   // Shared bus; nobody driving shows the inverse of the last value
   // ----------------------------------------
   assign o_bus = i_host_oe ? i_host_data : (i_dev_oe ? i_dev_data : ~last);
endmodule // dcfpf_port_host
`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 0, rst = 1, ets = 1, spn = 1, sen_n = 1, sd = 0;
   logic a_cs_n = 1, a_dir = 0, a_en = 0, a_mbx = 0, a_hoe = 0;
   logic b_cs_n = 1, b_dir = 0, b_en = 0, b_mbx = 0, b_hoe = 0;
   logic [35:0] a_hd = '0, b_hd = '0, q;
   logic oe;
   wire logic [35:0] a_q, b_q, bus_a, bus_b;
   wire logic a_oe, b_oe, pa, pb, rflag, wflag, ae_n, af_n, m1_n, m2_n, ftm;
   int fails = 0, checked = 0;

   initial forever #10 clk = ~clk;

   dcfpf_port_host #(.HALF(5)) host_a (.i_clk(clk), .i_host_oe(a_hoe), .i_host_data(a_hd),
      .i_dev_oe(a_oe), .i_dev_data(a_q), .o_port_clock(pa), .o_bus(bus_a));
   dcfpf_port_host #(.HALF(6)) host_b (.i_clk(clk), .i_host_oe(b_hoe), .i_host_data(b_hd),
      .i_dev_oe(b_oe), .i_dev_data(b_q), .o_port_clock(pb), .o_bus(bus_b));

   dcfpf_top #(.DEPTH(16)) dut (.i_clk(clk), .i_rst(rst), .i_port_a_clock(pa),
      .i_port_a_chip_select_n(a_cs_n), .i_port_a_direction(a_dir), .i_port_a_enable(a_en),
      .i_port_a_mailbox_select(a_mbx), .i_port_a_data(bus_a), .o_port_a_data(a_q),
      .o_port_a_data_oe(a_oe), .i_port_b_clock(pb), .i_port_b_chip_select_n(b_cs_n),
      .i_port_b_direction(b_dir), .i_port_b_enable(b_en), .i_port_b_mailbox_select(b_mbx),
      .i_port_b_data(bus_b), .o_port_b_data(b_q), .o_port_b_data_oe(b_oe),
      .i_endian_timing_select(ets), .i_serial_program_n(spn), .i_serial_enable_n(sen_n),
      .i_serial_data(sd), .o_read_side_flag(rflag), .o_write_side_flag(wflag),
      .o_almost_empty_flag_n(ae_n), .o_almost_full_flag_n(af_n), .o_mail_a_to_b_flag_n(m1_n),
      .o_mail_b_to_a_flag_n(m2_n), .o_fall_through_mode(ftm));

   // ----------------------------------------
   // Checking and closing
   // ----------------------------------------
   task automatic conclude;
      $display("checks %0d fails %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk_word(input logic [35:0] got, input logic [35:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      chk_word({35'h0, got}, {35'h0, exp}, what);
   endtask

   function automatic logic cur(input int s);
      case (s)
         0: return pa;
         1: return pb;
         2: return rflag;
         default: return wflag;
      endcase
   endfunction

   task automatic wait_until(input int s, input logic v);
      int n;
      for (n = 0; n < 200 && cur(s) !== v; n++) @(posedge clk);
      if (n == 200) begin
         fails++;
         $display("wrong value at %0t: wait ran out", $time);
         conclude();
      end
   endtask

   // ----------------------------------------
   // Port access: one port clock cycle, bus captured before release
   // ----------------------------------------
   task automatic port_op(input bit b, input logic dir, input logic en, input logic mbx,
         input logic [35:0] d);
      @(posedge clk);
      wait_until(b, 1'b0);
      #1;
      if (b) {b_cs_n, b_dir, b_en, b_mbx, b_hd, b_hoe} = {1'b0, dir, en, mbx, d, ~dir};
      else {a_cs_n, a_dir, a_en, a_mbx, a_hd, a_hoe} = {1'b0, dir, en, mbx, d, dir};
      wait_until(b, 1'b1);
      wait_until(b, 1'b0);
      repeat (2) @(posedge clk);
      #1;
      q = b ? bus_b : bus_a;
      oe = b ? b_oe : a_oe;
      if (b) {b_cs_n, b_en, b_mbx, b_hoe} = 4'h8;
      else {a_cs_n, a_en, a_mbx, a_hoe} = 4'h8;
   endtask

   task automatic ser_bit(input logic v);
      @(posedge clk);
      wait_until(0, 1'b0);
      #1;
      {sen_n, sd} = {1'b0, v};
      wait_until(0, 1'b1);
      wait_until(0, 1'b0);
      #1;
      sen_n = 1'b1;
   endtask

   task automatic settle;
      repeat (60) @(posedge clk);
      #1;
   endtask

   task automatic do_reset(input logic mode_v, input logic prog_v);
      @(posedge clk);
      #1;
      {rst, ets, spn} = {1'b1, mode_v, prog_v};
      repeat (3) @(posedge clk);
      chk_word({27'h0, a_oe, b_oe, rflag, wflag, ae_n, af_n, m1_n, m2_n, ftm}, 36'h0e, "reset");
      #1;
      rst = 1'b0;
      wait_until(0, 1'b1);
      wait_until(0, 1'b0);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      do_reset(1'b1, 1'b1);
      wait_until(3, 1'b1);
      chk_bit(ftm, 1'b0, "standard mode");
      chk_word({34'h0, a_oe, b_oe}, 36'h0, "idle float");
      port_op(1, 1, 1, 0, '0);
      chk_word(q, 36'h0, "read while empty");
      chk_bit(oe, 1'b1, "port b drives");
      for (int i = 0; i < 17; i++) begin
         port_op(0, 1, 1, 0, 36'h900000000 + 36'(i));
         chk_bit(oe, 1'b0, "port a floats on write");
         if (i == 6 || i == 7 || i == 8) begin
            settle();
            chk_word({33'h0, rflag, ae_n, af_n}, {33'h0, 1'b1, i == 8, i < 7}, "levels");
         end
      end
      settle();
      chk_bit(wflag, 1'b0, "full");
      for (int i = 0; i < 16; i++) begin
         port_op(1, 1, 1, 0, '0);
         chk_word(q, 36'h900000000 + 36'(i), "fifo order");
      end
      settle();
      chk_bit(rflag, 1'b0, "empty");
      chk_bit(wflag, 1'b1, "space again");
      port_op(1, 1, 1, 0, '0);
      chk_word(q, 36'h90000000f, "read refused");
      port_op(0, 1, 1, 0, 36'h5a5a5a5a5);
      settle();
      port_op(1, 1, 1, 0, '0);
      chk_word(q, 36'h5a5a5a5a5, "after wrap");
      port_op(0, 1, 1, 1, 36'h111111111);
      port_op(0, 1, 1, 1, 36'h222222222);
      settle();
      chk_bit(m1_n, 1'b0, "mail to b");
      port_op(1, 1, 1, 1, '0);
      chk_word(q, 36'h111111111, "mail read b");
      port_op(1, 0, 1, 0, 36'h333333333);
      chk_bit(oe, 1'b0, "port b floats on write");
      settle();
      chk_word({34'h0, m1_n, m2_n}, 36'h3, "mail flags");
      port_op(1, 0, 1, 1, 36'h444444444);
      settle();
      chk_bit(m2_n, 1'b0, "mail to a");
      port_op(0, 0, 1, 1, '0);
      chk_word({q[34:0], oe}, {35'h444444444, 1'b1}, "mail read a");
      do_reset(1'b0, 1'b0);
      for (int k = 7; k >= 0; k--) begin
         chk_bit(wflag, 1'b0, "space low while loading");
         ser_bit(k > 3 ? 1'(4'h4 >> (k - 4)) : 1'(4'h2 >> k));
      end
      wait_until(3, 1'b1);
      chk_bit(ftm, 1'b1, "fall-through mode");
      port_op(0, 1, 1, 0, 36'ha00000000);
      wait_until(2, 1'b1);
      port_op(1, 1, 0, 0, '0);
      chk_word(q, 36'ha00000000, "fall through");
      for (int i = 1; i < 4; i++) begin
         port_op(0, 1, 1, 0, 36'ha00000000 + 36'(i));
         settle();
         chk_bit(ae_n, i == 3, "fill excludes output");
      end
      port_op(1, 1, 0, 0, '0);
      chk_word(q, 36'ha00000000, "no read no load");
      for (int i = 1; i < 4; i++) begin
         port_op(1, 1, 1, 0, '0);
         chk_word(q, 36'ha00000000 + 36'(i), "fall_through_mode order");
      end
      conclude();
   end
endmodule // tb
`default_nettype wire
